// ---- hdl/field_pkg.sv ----
/*
 * Package for the magnetometer result block: register offsets, status
 * layout, reset values and the carrier structs.
 * Assumes a byte-wide register port driven by a serial interface front end
 * on the same clock.
 */
package field_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] THRESHOLD_LOW_ADDR  = 8'h65;
    localparam logic [7:0] THRESHOLD_HIGH_ADDR = 8'h66;
    localparam logic [7:0] FIELD_STATUS_ADDR   = 8'h67;
    localparam logic [7:0] FIELD_X_LOW_ADDR    = 8'h68;
    localparam logic [7:0] FIELD_X_HIGH_ADDR   = 8'h69;
    localparam logic [7:0] FIELD_Y_LOW_ADDR    = 8'h6a;
    localparam logic [7:0] FIELD_Y_HIGH_ADDR   = 8'h6b;
    localparam logic [7:0] FIELD_Z_LOW_ADDR    = 8'h6c;
    localparam logic [7:0] FIELD_Z_HIGH_ADDR   = 8'h6d;

    // ------------------------------------------------------------------
    // Status field positions
    // ------------------------------------------------------------------
    localparam int STATUS_ALL_OVERRUN_BIT = 7;
    localparam int STATUS_OVERRUN_LSB     = 4;
    localparam int STATUS_ALL_READY_BIT   = 3;
    localparam int STATUS_READY_LSB       = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
    localparam logic [7:0]  STATUS_RESET    = 8'h00;
    localparam logic [15:0] FIELD_RESET     = 16'h0000;
    localparam logic [7:0]  READ_UNMAPPED   = 8'h00;

    localparam int AXES = 3;

    // Raw sample set from the sensing front end
    typedef struct packed {
        logic               valid;
        logic [2:0]         axis_valid;
        logic signed [15:0] x;
        logic signed [15:0] y;
        logic signed [15:0] z;
    } sample_t;

    // Register port request from the serial interface
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } reg_rsp_t;

endpackage

// ---- hdl/axis_compare.sv ----
/*
 * One axis: hard-iron correction and two-sided threshold compare.
 * Assumes offset and threshold are stable register values on the same clock.
 */
`timescale 1ns/1ps
module axis_compare #(
    parameter int W = 16
) (
    input  wire logic signed [W-1:0] raw,
    input  wire logic signed [W-1:0] offset,
    input  wire logic        [W-1:0] threshold,
    output logic signed      [W-1:0] corrected,
    output logic                     exceed_pos,
    output logic                     exceed_neg
);
    logic signed [W+1:0] thr_wide;
    logic signed [W+1:0] val_wide;

    always_comb begin
        // Zero offset leaves the raw value untouched
        corrected = (offset == '0) ? raw : W'(raw - offset);
        // Threshold is an unsigned magnitude, compared on both sides
        thr_wide  = $signed({2'b00, threshold});
        val_wide  = (W+2)'(corrected);
        exceed_pos = val_wide > thr_wide;
        exceed_neg = val_wide < -thr_wide;
    end
endmodule

// ---- hdl/field_result.sv ----
/*
 * Magnetometer result registers: shared threshold, status byte, field
 * outputs and per-axis threshold flags.
 * Assumes a serial interface front end presents byte reads and writes as
 * one-cycle strobes on this clock, and a sensing front end delivers samples
 * on this clock.
 */
`timescale 1ns/1ps
//
// Contract
// - The upper threshold byte is a writable register at 66h.
// - One unsigned threshold magnitude applies to all three axes.
// - Each axis flags exceeding the threshold above and below its negation.
// - The status byte at 67h is read only; writes are ignored.
// - Status holds all-overrun, z/y/x overrun, all-ready, z/y/x ready.
// - All-overrun sets when a full new set replaces an unread set.
// - An axis overrun sets when new axis data replaces unread axis data.
// - All-ready sets when a complete new three-axis set is available.
// - An axis ready sets when fresh data for that axis is available.
// - X sample is presented low byte at 68h, high byte at 69h.
// - Y sample is presented low byte at 6Ah, high byte at 6Bh.
// - Z sample is presented low byte at 6Ch, high byte at 6Dh.
// - Samples are two's complement across low and high bytes.
// - Output is raw with zero offset, offset-corrected otherwise.
// - The lower threshold byte is a writable register at 65h.
// - Threshold events show as positive and negative flags per axis.
module field_result
    import field_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic                clk_en,
    input  wire reg_req_t            req,
    output reg_rsp_t                 rsp,
    input  wire sample_t             sample,
    input  wire logic signed [W-1:0] offset_x,
    input  wire logic signed [W-1:0] offset_y,
    input  wire logic signed [W-1:0] offset_z,
    output logic [2:0]               positive_exceed,
    output logic [2:0]               negative_exceed
);
    initial begin
        if (W != 16) $error("field_result supports only 16-bit samples");
    end

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [15:0]          shared_threshold_q;
    logic signed [15:0]   field_q [AXES];
    logic [2:0]           ready_q;
    logic [2:0]           overrun_q;
    logic                 all_ready_q;
    logic                 all_overrun_q;
    logic [2:0]           read_seen_q;
    logic [2:0]           positive_exceed_q;
    logic [2:0]           negative_exceed_q;
    reg_rsp_t             rsp_q;

    logic signed [15:0]   raw    [AXES];
    logic signed [15:0]   offs   [AXES];
    logic signed [15:0]   corr   [AXES];
    logic [2:0]           pos_hit;
    logic [2:0]           neg_hit;
    logic [2:0]           axis_new;
    logic [2:0]           axis_read;
    logic [2:0]           seen_d;
    logic                 set_done;
    logic [7:0]           status;

    assign raw[0]  = sample.x;
    assign raw[1]  = sample.y;
    assign raw[2]  = sample.z;
    assign offs[0] = offset_x;
    assign offs[1] = offset_y;
    assign offs[2] = offset_z;

    // ------------------------------------------------------------------
    // Per-axis correction and compare
    // ------------------------------------------------------------------
    for (genvar a = 0; a < AXES; a++) begin : g_axis
        axis_compare #(.W(16)) u_cmp (
            .raw        (raw[a]),
            .offset     (offs[a]),
            .threshold  (shared_threshold_q),
            .corrected  (corr[a]),
            .exceed_pos (pos_hit[a]),
            .exceed_neg (neg_hit[a])
        );
    end

    assign axis_new = sample.valid ? sample.axis_valid : 3'b000;

    // ------------------------------------------------------------------
    // Read decode: an axis counts as read once its high byte is read
    // ------------------------------------------------------------------
    always_comb begin
        axis_read = 3'b000;
        if (req.rd) begin
            case (req.addr)
                FIELD_X_HIGH_ADDR: axis_read = 3'b001;
                FIELD_Y_HIGH_ADDR: axis_read = 3'b010;
                FIELD_Z_HIGH_ADDR: axis_read = 3'b100;
                default:           axis_read = 3'b000;
            endcase
        end
    end

    // Combined flags clear once every axis has been read
    assign seen_d   = read_seen_q | axis_read;
    assign set_done = &seen_d;

    assign status = {all_overrun_q, overrun_q, all_ready_q, ready_q};

    // ------------------------------------------------------------------
    // Threshold registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shared_threshold_q <= THRESHOLD_RESET;
        end else if (clk_en && req.wr) begin
            if (req.addr == THRESHOLD_LOW_ADDR) begin
                shared_threshold_q[7:0] <= req.wdata;
            end
            if (req.addr == THRESHOLD_HIGH_ADDR) begin
                shared_threshold_q[15:8] <= req.wdata;
            end
            // Writes to status and output bytes are dropped
        end
    end

    // ------------------------------------------------------------------
    // Output samples
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int a = 0; a < AXES; a++) begin
                field_q[a] <= FIELD_RESET;
            end
        end else if (clk_en) begin
            for (int a = 0; a < AXES; a++) begin
                if (axis_new[a]) begin
                    field_q[a] <= corr[a];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-axis ready and overrun; a new sample wins over a read clear
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ready_q   <= STATUS_RESET[2:0];
            overrun_q <= STATUS_RESET[6:4];
        end else if (clk_en) begin
            for (int a = 0; a < AXES; a++) begin
                if (axis_new[a]) begin
                    ready_q[a] <= 1'b1;
                    if (ready_q[a] && !axis_read[a]) begin
                        overrun_q[a] <= 1'b1;
                    end
                end else if (axis_read[a]) begin
                    ready_q[a]   <= 1'b0;
                    overrun_q[a] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Combined ready and overrun
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            all_ready_q   <= STATUS_RESET[STATUS_ALL_READY_BIT];
            all_overrun_q <= STATUS_RESET[STATUS_ALL_OVERRUN_BIT];
            read_seen_q   <= 3'b000;
        end else if (clk_en) begin
            if (sample.valid && (&sample.axis_valid)) begin
                all_ready_q <= 1'b1;
                // A whole set landing over an unread set is an overrun
                if (all_ready_q && !set_done) begin
                    all_overrun_q <= 1'b1;
                end
                read_seen_q <= 3'b000;
            end else if (set_done) begin
                all_ready_q   <= 1'b0;
                all_overrun_q <= 1'b0;
                read_seen_q   <= 3'b000;
            end else begin
                read_seen_q <= seen_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // Threshold event flags, refreshed on each new axis result
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            positive_exceed_q <= 3'b000;
            negative_exceed_q <= 3'b000;
        end else if (clk_en) begin
            for (int a = 0; a < AXES; a++) begin
                if (axis_new[a]) begin
                    positive_exceed_q[a] <= pos_hit[a];
                    negative_exceed_q[a] <= neg_hit[a];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rsp_q <= '0;
        end else if (clk_en) begin
            rsp_q.valid <= req.rd;
            if (req.rd) begin
                case (req.addr)
                    THRESHOLD_LOW_ADDR:  rsp_q.rdata <= shared_threshold_q[7:0];
                    THRESHOLD_HIGH_ADDR: rsp_q.rdata <= shared_threshold_q[15:8];
                    FIELD_STATUS_ADDR:   rsp_q.rdata <= status;
                    // Two's complement split low then high
                    FIELD_X_LOW_ADDR:    rsp_q.rdata <= field_q[0][7:0];
                    FIELD_X_HIGH_ADDR:   rsp_q.rdata <= field_q[0][15:8];
                    FIELD_Y_LOW_ADDR:    rsp_q.rdata <= field_q[1][7:0];
                    FIELD_Y_HIGH_ADDR:   rsp_q.rdata <= field_q[1][15:8];
                    FIELD_Z_LOW_ADDR:    rsp_q.rdata <= field_q[2][7:0];
                    FIELD_Z_HIGH_ADDR:   rsp_q.rdata <= field_q[2][15:8];
                    default:             rsp_q.rdata <= READ_UNMAPPED;
                endcase
            end
        end
    end

    assign rsp             = rsp_q;
    assign positive_exceed = positive_exceed_q;
    assign negative_exceed = negative_exceed_q;

endmodule

// ---- dv/host_model.sv ----
/*
 * Host side of the register port: issues one byte read or write per call.
 * Assumes the caller runs on the same clock and waits for read data itself.
 */
`timescale 1ns/1ps
module host_model
    import field_pkg::*;
(
    input  wire logic clock,
    output reg_req_t  req
);
    initial req = '0;

    // Holds the strobe for exactly one taken edge, then drops it and
    // scrambles address and data so stale values never look valid
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [7:0] d);
        @(posedge clock);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clock);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

// ---- dv/field_result_sva.sv ----
/*
 * Checker for the magnetometer result block, bound to its top module.
 * Assumes the read response follows the one-cycle answer of the port.
 */
`timescale 1ns/1ps
module field_result_sva
    import field_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic                clk_en,
    input  wire reg_req_t            req,
    input  wire reg_rsp_t            rsp,
    input  wire sample_t             sample,
    input  wire logic signed [W-1:0] offset_x,
    input  wire logic signed [W-1:0] offset_y,
    input  wire logic signed [W-1:0] offset_z,
    input  wire logic [2:0]          positive_exceed,
    input  wire logic [2:0]          negative_exceed
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic signed [W-1:0] x_exp_q;
    logic                take_rd;
    logic                new_x;
    assign take_rd = clk_en && req.rd;
    assign new_x   = clk_en && sample.valid && sample.axis_valid[0];

    // Corrected X as the reader should see it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            x_exp_q <= '0;
        end else if (new_x) begin
            x_exp_q <= sample.x - offset_x;
        end
    end

    chk_rsp_after_rd: assert property (take_rd |=> rsp.valid)
        else $error("read not answered in one cycle");
    chk_rsp_only_rd: assert property (!take_rd |=> !rsp.valid)
        else $error("read answer without read");
    chk_unmapped_zero: assert property (take_rd && req.addr == 8'h70
        |=> rsp.rdata == READ_UNMAPPED)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!take_rd |=> $stable(rsp.rdata))
        else $error("read data moved without read");
    chk_exceed_excl: assert property ((positive_exceed & negative_exceed)
        == 3'b000)
        else $error("both exceed sides set");
    chk_exceed_hold: assert property (!new_x
        |=> $stable(positive_exceed[0]) && $stable(negative_exceed[0]))
        else $error("x exceed flag moved without sample");
    chk_x_low_read: assert property (take_rd && req.addr == FIELD_X_LOW_ADDR
        && !new_x |=> rsp.rdata == x_exp_q[7:0])
        else $error("x low byte wrong");
    chk_x_high_read: assert property (take_rd && !new_x
        && req.addr == FIELD_X_HIGH_ADDR |=> rsp.rdata == x_exp_q[15:8])
        else $error("x high byte wrong");

    cov_full_set: cover property (clk_en && sample.valid
        && sample.axis_valid == 3'b111);
    cov_status_rd: cover property (take_rd && req.addr == FIELD_STATUS_ADDR);
    cov_thr_wr: cover property (clk_en && req.wr
        && req.addr == THRESHOLD_HIGH_ADDR);
endmodule

bind field_result field_result_sva #(.W(W)) i_field_result_sva (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .req(req), .rsp(rsp),
    .sample(sample), .offset_x(offset_x), .offset_y(offset_y),
    .offset_z(offset_z), .positive_exceed(positive_exceed),
    .negative_exceed(negative_exceed));

// ---- dv/tb.sv ----
/*
 * Self-checking bench for the magnetometer result block.
 * Assumes the host model drives the register port; reads queue their
 * expected byte and a monitor compares it when the answer appears.
 */
`timescale 1ns/1ps
module tb;
    import field_pkg::*;
    logic                clock = 0;
    logic                rst_n = 0;
    logic                clk_en = 1;
    reg_req_t            req;
    reg_rsp_t            rsp;
    sample_t             sample = '0;
    logic signed [15:0]  ox = 0, oy = 0, oz = 0;
    logic signed [15:0]  c [3];
    logic [2:0]          pos, neg, pe, ne;
    logic [15:0]         thr;
    logic [7:0]          expq [$];
    int                  fails = 0, comparisons = 0, seed = 32'hb147;

    always #5 clock = ~clock;

    field_result i_field_result (.clock(clock), .rst_n(rst_n),
        .clk_en(clk_en), .req(req), .rsp(rsp), .sample(sample),
        .offset_x(ox), .offset_y(oy), .offset_z(oz),
        .positive_exceed(pos), .negative_exceed(neg));
    host_model i_host_model (.clock(clock), .req(req));

    // ------------------------------------------------------------------
    // Compare and transfer tasks
    // ------------------------------------------------------------------
    task automatic chk_byte(string n, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_flags(string n, logic [2:0] e, logic [2:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] e);
        expq.push_back(e);
        i_host_model.access(1'b0, a, 8'h00);
    endtask

    task automatic send(logic signed [15:0] x, y, z);
        @(posedge clock);
        sample <= '{valid: 1'b1, axis_valid: 3'b111, x: x, y: y, z: z};
        c[0] = x - ox;
        c[1] = y - oy;
        c[2] = z - oz;
        for (int i = 0; i < 3; i++) begin
            pe[i] = int'(c[i]) > int'(thr);
            ne[i] = int'(c[i]) < -int'(thr);
        end
        @(posedge clock);
        sample.valid <= 1'b0;
        #1;
        chk_flags("positive_exceed", pe, pos);
        chk_flags("negative_exceed", ne, neg);
    endtask

    task automatic read_fields();
        for (int i = 0; i < 3; i++) begin
            rd(FIELD_X_LOW_ADDR + 8'(2 * i), c[i][7:0]);
            rd(FIELD_X_HIGH_ADDR + 8'(2 * i), c[i][15:8]);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        if (rsp.valid === 1'b1) begin
            if (expq.size() == 0) begin
                chk_byte("unexpected read", 8'h00, 8'hff);
            end else begin
                chk_byte("rdata", expq.pop_front(), rsp.rdata);
            end
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1;
        for (int a = 8'h65; a <= 8'h70; a++) begin
            rd(8'(a), 8'h00);
        end
        $display("test reset_values done");
        thr = 16'($random(seed)) & 16'h0fff;
        i_host_model.access(1'b1, THRESHOLD_LOW_ADDR, thr[7:0]);
        i_host_model.access(1'b1, THRESHOLD_HIGH_ADDR, thr[15:8]);
        i_host_model.access(1'b1, FIELD_STATUS_ADDR, 8'hff);
        rd(THRESHOLD_LOW_ADDR, thr[7:0]);
        rd(THRESHOLD_HIGH_ADDR, thr[15:8]);
        rd(FIELD_STATUS_ADDR, STATUS_RESET);
        $display("test threshold done");
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            ox <= (k == 0) ? 16'h0000 : 16'($random(seed));
            oy <= (k == 0) ? 16'h0000 : 16'($random(seed));
            oz <= (k == 0) ? 16'h0000 : 16'($random(seed));
            send($signed(16'($random(seed))) >>> (4 * k),
                 $signed(16'($random(seed))) >>> (4 * k),
                 $signed(16'($random(seed))) >>> (4 * k));
            rd(FIELD_STATUS_ADDR, 8'h0f);
            read_fields();
            rd(FIELD_STATUS_ADDR, 8'h00);
        end
        $display("test fields done");
        // A sample offered while the clock enable is low must be ignored
        @(posedge clock);
        clk_en <= 1'b0;
        sample <= '{valid: 1'b1, axis_valid: 3'b111,
                    x: 16'sh7fff, y: 16'sh7fff, z: 16'sh7fff};
        @(posedge clock);
        sample.valid <= 1'b0;
        clk_en <= 1'b1;
        rd(FIELD_STATUS_ADDR, STATUS_RESET);
        $display("test freeze done");
        send(16'sh1234, -16'sh0567, 16'sh7fff);
        send(-16'sh8000, 16'sh0001, -16'sh0100);
        rd(FIELD_STATUS_ADDR, 8'hff);
        read_fields();
        rd(FIELD_STATUS_ADDR, 8'h00);
        $display("test overrun done");
        for (int n = 0; n < 20 && expq.size() != 0; n++) begin
            @(posedge clock);
        end
        if (expq.size() != 0) begin
            chk_byte("pending reads", 8'h00, 8'(expq.size()));
        end
        test_done();
    end
endmodule
